/* File: hw/sps_standby_pin_ctrl.v */
`include "sps_defines.vh"
`default_nettype none

module sps_standby_pin_ctrl (
  input wire core_clk_in,
  input wire nrst_in,
  input wire reset_n_in,
  input wire hw_standby_n_in,
  input wire sw_standby_req_in,
  input wire ram_enable_bit_in,
  input wire [7:0] pin_dir_in,
  input wire [7:0] pin_output_value_in,
  input wire [7:0] pullup_control_bit_in,
  input wire [7:0] periph_sel_in,
  input wire [7:0] periph_oe_in,
  input wire [7:0] periph_out_in,
  output reg [7:0] pin_out_out,
  output reg [7:0] pin_oe_out,
  output reg [7:0] pin_pullup_out,
  output reg [3:0] proc_state_out,
  output reg ram_retain_out
);

  localparam ST_RESET = `SPS_ST_RESET;
  localparam ST_HWSTBY = `SPS_ST_HWSTBY;
  localparam ST_SWSTBY = `SPS_ST_SWSTBY;
  localparam ST_RUN = `SPS_ST_RUN;

  reg [1:0] rst_sync_reg;
  reg [1:0] standby_sync_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [3:0] lead_cnt_reg;
  reg [7:0] hold_out_reg;
  reg [7:0] hold_oe_reg;
  reg [7:0] pin_out_next;
  reg [7:0] pin_oe_next;
  reg [7:0] pin_pullup_next;
  reg ram_retain_next;
  wire rst_act;
  wire standby_act;
  wire sw_entry;
  wire lead_met;
  // port view while running, per pin
  wire [7:0] run_oe;
  wire [7:0] run_out;
  wire [7:0] run_pull;
  // frozen port view used in software standby
  wire [7:0] frz_oe;
  wire [7:0] frz_out;
  genvar gi;

  // a state is entered on this edge when it is next but not yet current;
  // both entry points must see the same decision, hence one decoder
  function entering;
    input [3:0] cur_st;
    input [3:0] nxt_st;
    input [3:0] target_st;
    begin
      entering = (nxt_st == target_st) && (cur_st != target_st);
    end
  endfunction

  // the reset pin is asynchronous to the core clock, so it passes two
  // flops; only the second flop of the chain is ever read
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], reset_n_in};
    end
  end

  // the standby chain resets to released, so leaving reset never passes
  // through a false hardware standby; a pin really low shows two edges on
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      standby_sync_reg <= 2'h3;
    end else begin
      standby_sync_reg <= {standby_sync_reg[0], hw_standby_n_in};
    end
  end

  assign rst_act = ~rst_sync_reg[1];
  assign standby_act = ~standby_sync_reg[1];

  // the software standby capture edge, shared by the hold registers and
  // the output mux so that both see the same port bits
  assign sw_entry = entering(state_reg, state_next, ST_SWSTBY);

  // the ram lead is met once the counter has saturated; it only counts
  // while the synchronised reset is low, so a glitch restarts it
  assign lead_met = (lead_cnt_reg == `SPS_RAM_LEAD_CYC);

  // per-pin port logic: while running, a peripheral that owns a pin
  // drives it and otherwise the direction and data bits do; pull-ups
  // only make sense on pins that are not driven by the port
  generate
    for (gi = 0; gi < `SPS_NPINS; gi = gi + 1) begin : g_pin
      assign run_oe[gi] = periph_sel_in[gi] ? periph_oe_in[gi] :
        pin_dir_in[gi];
      assign run_out[gi] = periph_sel_in[gi] ? periph_out_in[gi] :
        pin_output_value_in[gi];
      assign run_pull[gi] = ~pin_dir_in[gi] & pullup_control_bit_in[gi];
      // on the entry edge the hold copy is not written yet, so the live
      // port bits are used there and the copy on every later edge
      assign frz_oe[gi] = sw_entry ? pin_dir_in[gi] : hold_oe_reg[gi];
      assign frz_out[gi] = sw_entry ? pin_output_value_in[gi] :
        hold_out_reg[gi];
    end
  endgenerate

  // count how long reset has been low, saturating at the ram lead so that
  // a long reset never wraps back below it
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lead_cnt_reg <= 4'h0;
    end else if (!rst_act) begin
      lead_cnt_reg <= 4'h0;
    end else if (!lead_met) begin
      lead_cnt_reg <= lead_cnt_reg + 4'h1;
    end
  end

  // hardware standby overrides everything, then reset, then software;
  // the supervisor's own timing is not policed here, a short reset lead
  // only costs the ram retention flag
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET, ST_HWSTBY, ST_SWSTBY, ST_RUN: begin
        if (standby_act)
          state_next = ST_HWSTBY;
        else if (rst_act)
          state_next = ST_RESET;
        else if (state_reg == ST_RUN && sw_standby_req_in)
          state_next = ST_SWSTBY;
        else if (state_reg == ST_SWSTBY && !sw_standby_req_in)
          state_next = ST_RUN;
        else if (state_reg == ST_RESET || state_reg == ST_HWSTBY)
          state_next = ST_RUN;
      end
      default: state_next = ST_RESET;
    endcase
  end

  // ram contents survive only if reset led standby long enough
  always @* begin
    ram_retain_next = ram_retain_out;
    if (entering(state_reg, state_next, ST_HWSTBY))
      ram_retain_next = ram_enable_bit_in && rst_act &&
        lead_met;
    else if (state_next == ST_RUN)
      ram_retain_next = 1'b0;
  end

  // pin drive per state; peripherals only own pins while running
  always @* begin
    pin_out_next = 8'h00;
    pin_oe_next = 8'h00;
    pin_pullup_next = 8'h00;
    case (state_next)
      ST_RUN: begin
        pin_oe_next = run_oe;
        pin_out_next = run_out;
        pin_pullup_next = run_pull;
      end
      ST_SWSTBY: begin
        // peripherals are reset here, so the frozen port value stands
        pin_oe_next = frz_oe;
        pin_out_next = frz_out;
        pin_pullup_next = ~frz_oe & pullup_control_bit_in;
        // the clock pin is parked high when it is an output
        pin_out_next[`SPS_CLK_PIN] = frz_oe[`SPS_CLK_PIN];
      end
      ST_RESET, ST_HWSTBY: begin
        pin_oe_next = 8'h00;
      end
      default: pin_oe_next = 8'h00;
    endcase
  end

  // capture plain port settings on the way into software standby
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_out_reg <= `SPS_PIN_RST;
      hold_oe_reg <= `SPS_PIN_RST;
    end else if (sw_entry) begin
      hold_out_reg <= pin_output_value_in;
      hold_oe_reg <= pin_dir_in;
    end
  end

  // registered outputs
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_RESET;
      proc_state_out <= ST_RESET;
      pin_out_out <= `SPS_PIN_RST;
      pin_oe_out <= `SPS_PIN_RST;
      pin_pullup_out <= `SPS_PIN_RST;
      ram_retain_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      proc_state_out <= state_next;
      pin_out_out <= pin_out_next;
      pin_oe_out <= pin_oe_next;
      pin_pullup_out <= pin_pullup_next;
      ram_retain_out <= ram_retain_next;
    end
  end

endmodule

`default_nettype wire

/* File: hw/sps_defines.vh */
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// number of general port pins handled by the block
`define SPS_NPINS 8
// index of the clock-capable pin
`define SPS_CLK_PIN 6
// reset value of every latched direction, data and pull-up bit
`define SPS_PIN_RST 8'h00
// processing state codes, one-hot
`define SPS_ST_RESET 4'h1
`define SPS_ST_HWSTBY 4'h2
`define SPS_ST_SWSTBY 4'h4
`define SPS_ST_RUN 4'h8
// reset-to-standby lead for ram retention, in system clock cycles
`define SPS_RAM_LEAD_CYC 4'hA
// reset-before-standby-release lead, in ns, and as cycles (rounded up)
`define SPS_REC_LEAD_NS 100
`define SPS_CLK_NS 50
`define SPS_REC_LEAD_CYC ((`SPS_REC_LEAD_NS + `SPS_CLK_NS - 1) / `SPS_CLK_NS)

`endif

/* File: tb/sps_standby_pin_ctrl_props.sv */
`default_nettype none
module sps_props (
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] pin_dir_in,
  input wire logic [7:0] pin_output_value_in,
  input wire logic [7:0] pullup_control_bit_in,
  input wire logic [7:0] pin_out_out,
  input wire logic [7:0] pin_oe_out,
  input wire logic [7:0] pin_pullup_out,
  input wire logic [3:0] proc_state_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  // standby entry must snapshot the port setup of the edge before
  in_float_a: assert property ($rose(proc_state_out[2]) |->
    pin_oe_out == $past(pin_dir_in)) else $error("oe at entry");
  pull_keep_a: assert property ($rose(proc_state_out[2]) |->
    pin_pullup_out == (~$past(pin_dir_in) & $past(pullup_control_bit_in)))
    else $error("pullup at entry");
  port_back_a: assert property ($rose(proc_state_out[2]) |->
    (pin_out_out & 8'hBF) == ($past(pin_output_value_in) & 8'hBF))
    else $error("port value at entry");
  out_hold_a: assert property (proc_state_out[2] ##1
    proc_state_out[2] |-> $stable(pin_out_out)) else $error("hold");
  clk_pin_a: assert property (proc_state_out[2] |->
    pin_out_out[6] == pin_oe_out[6]) else $error("clock pin");
  all_float_a: assert property (proc_state_out[1:0] != 2'h0 |->
    pin_oe_out == 8'h00) else $error("pins driven");
endmodule
bind sps_standby_pin_ctrl sps_props i_props (
  .core_clk_in(core_clk_in),
  .nrst_in(nrst_in),
  .pin_dir_in(pin_dir_in),
  .pin_output_value_in(pin_output_value_in),
  .pullup_control_bit_in(pullup_control_bit_in),
  .pin_out_out(pin_out_out),
  .pin_oe_out(pin_oe_out),
  .pin_pullup_out(pin_pullup_out),
  .proc_state_out(proc_state_out)
);
`default_nettype wire

/* File: tb/sps_supervisor.sv */
`default_nettype none
module sps_supervisor (
  input wire logic clk_in,
  output logic rst_pin_n_out = 1'h1,
  output logic standby_pin_n_out = 1'h1
);
  timeunit 1ns;
  timeprecision 1ns;
  // without retention the reset lead is simply skipped; a lead below ten
  // cycles is only used to show that retention is then lost
  task automatic enter_hw(input bit keep, input int lead);
    rst_pin_n_out = !keep;
    repeat (lead) @(negedge clk_in);
    standby_pin_n_out = 1'h0;
    @(negedge clk_in);
    rst_pin_n_out = 1'h1;
  endtask
  // reset leads the standby release by two cycles, 100 ns
  task automatic leave_hw;
    rst_pin_n_out = 1'h0;
    repeat (2) @(negedge clk_in);
    standby_pin_n_out = 1'h1;
    @(negedge clk_in);
    rst_pin_n_out = 1'h1;
  endtask
endmodule
`default_nettype wire

/* File: tb/sps_standby_pin_ctrl_bench.sv */
`default_nettype none
module sps_standby_pin_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 0, nrst_in = 0, sw_standby_req_in = 0;
  logic ram_enable_bit_in = 1;
  logic [7:0] pin_dir_in = 8'hC3, pin_output_value_in = 8'h35;
  logic [7:0] pullup_control_bit_in = 8'hF0, periph_sel_in = 8'h0F;
  logic [7:0] periph_oe_in = 8'hFF, periph_out_in = 8'hCA;
  logic [7:0] pin_out_out, pin_oe_out, pin_pullup_out;
  logic [3:0] proc_state_out;
  logic ram_retain_out;
  wire reset_n_in, hw_standby_n_in;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  sps_standby_pin_ctrl i_dut (
    .core_clk_in(core_clk_in),
    .nrst_in(nrst_in),
    .reset_n_in(reset_n_in),
    .hw_standby_n_in(hw_standby_n_in),
    .sw_standby_req_in(sw_standby_req_in),
    .ram_enable_bit_in(ram_enable_bit_in),
    .pin_dir_in(pin_dir_in),
    .pin_output_value_in(pin_output_value_in),
    .pullup_control_bit_in(pullup_control_bit_in),
    .periph_sel_in(periph_sel_in),
    .periph_oe_in(periph_oe_in),
    .periph_out_in(periph_out_in),
    .pin_out_out(pin_out_out),
    .pin_oe_out(pin_oe_out),
    .pin_pullup_out(pin_pullup_out),
    .proc_state_out(proc_state_out),
    .ram_retain_out(ram_retain_out)
  );
  sps_supervisor i_sup (.clk_in(core_clk_in), .rst_pin_n_out(reset_n_in),
    .standby_pin_n_out(hw_standby_n_in));
  always #25 core_clk_in = ~core_clk_in;
  // a hung wait ends the run as a failure
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] seen, exp, input string nm);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_st(input logic [3:0] st);
    for (int n = 0; n < 20 && proc_state_out !== st; n++)
      @(negedge core_clk_in);
    chk(proc_state_out, st, "state");
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge core_clk_in);
    wait_st(4'h1);
    chk(pin_oe_out, 8'h00, "reset oe");
    @(negedge core_clk_in);
    nrst_in = 1;
    // clock pin as output first, then as input; data moves meanwhile
    repeat (2) begin
      wait_st(4'h8);
      chk(pin_out_out, 8'h3A, "run out");
      chk(pin_oe_out, 8'h0F | (pin_dir_in & 8'hF0), "run oe");
      sw_standby_req_in = 1;
      wait_st(4'h4);
      chk(pin_oe_out, pin_dir_in, "oe");
      chk(pin_pullup_out, ~pin_dir_in & 8'hF0, "pullup");
      pin_output_value_in = 8'h00;
      repeat (3) @(negedge core_clk_in);
      chk(pin_out_out, {1'h0, pin_dir_in[6], 6'h35}, "out");
      chk(pin_out_out[6], pin_dir_in[6], "clk pin");
      sw_standby_req_in = 0;
      pin_output_value_in = 8'h35;
      pin_dir_in = 8'h0F;
    end
    // retained entry, a short reset lead, ram disabled, no reset lead
    for (int k = 3; k >= 0; k--) begin
      wait_st(4'h8);
      chk(ram_retain_out, 8'h00, "run retain");
      ram_enable_bit_in = (k != 1);
      i_sup.enter_hw(k != 0, (k == 2) ? 9 : 10);
      wait_st(4'h2);
      chk(pin_oe_out, 8'h00, "hw oe");
      chk(ram_retain_out, k == 3, "retain");
      i_sup.leave_hw();
    end
    wait_st(4'h8);
    wrap_up();
  end
endmodule
`default_nettype wire
